// ### inc/coder_pkg.sv
// Shared constants of the low-speed line coder
package coder_pkg;
	localparam int unsigned AHB_DW     = 32;
	localparam int unsigned CLK_HZ     = 40_000_000;
	localparam int unsigned BIT_HZ     = 1_500_000;
	localparam int unsigned RATE_UNIT  = 100_000;
	localparam logic [8:0]  ACC_STEP   = 9'(BIT_HZ / RATE_UNIT);
	localparam logic [8:0]  ACC_MOD    = 9'(CLK_HZ / RATE_UNIT);
	localparam logic [4:0]  RX_BIT_CYC = 5'(CLK_HZ / BIT_HZ);
	localparam logic [4:0]  RX_MID_CYC = 5'(CLK_HZ / BIT_HZ / 2);
	localparam logic [2:0]  STUFF_RUN  = 3'h6;
	localparam logic        LINE_IDLE  = 1'b1;
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0]  HSIZE_WORD = 3'h2;
	localparam logic [7:0]  EP_CTRL2_IDX  = 8'h37;
	localparam logic [31:0] EP_CTRL2_ADDR = 32'(EP_CTRL2_IDX) << 2;
	localparam logic [31:0] CTRL_ADDR  = 32'h0000_0100;
	localparam logic [31:0] STAT_ADDR  = 32'h0000_0104;
	localparam logic [31:0] MASK_ADDR  = 32'h0000_0108;
	localparam logic [31:0] LINE_ADDR  = 32'h0000_010C;
	localparam int          TX_FIRST_POS    = 5;
	localparam int          SECOND_ON_POS   = 3;
	localparam int          FIRST_ON_POS    = 2;
	localparam int          SECOND_HALT_POS = 1;
	localparam int          FIRST_HALT_POS  = 0;
	localparam logic [7:0]  EP_CTRL2_WMASK  = 8'((1 << TX_FIRST_POS) | (1 << SECOND_ON_POS)
		| (1 << FIRST_ON_POS) | (1 << SECOND_HALT_POS) | (1 << FIRST_HALT_POS));
	localparam logic [7:0]  EP_CTRL2_RST = 8'h00;
	localparam int          CTRL_EN_POS  = 0;
	localparam logic [7:0]  CTRL_WMASK   = 8'h01;
	localparam logic [7:0]  CTRL_RST     = 8'h01;
	localparam int          EVT_W        = 3;
	localparam int          EVT_RX_ERR   = 0;
	localparam int          EVT_TX_DONE  = 1;
	localparam int          EVT_RX_START = 2;
	localparam logic [2:0]  STAT_RST     = 3'h0;
	localparam logic [2:0]  MASK_RST     = 3'h0;
endpackage

// ### inc/coder_if.sv
// Signals between the line coder top and its helpers
interface coder_if;
	logic bit_stb;
	logic enable;
	logic tx_valid;
	logic tx_bit;
	logic tx_ready;
	logic tx_done;
	logic line_out;
	logic line_oe;
	logic raw_in;
	logic line_lvl;
	logic line_chg;
	modport top (output bit_stb, enable, tx_valid, tx_bit, raw_in,
		input tx_ready, tx_done, line_out, line_oe, line_lvl, line_chg);
	modport tx (input bit_stb, enable, tx_valid, tx_bit,
		output tx_ready, tx_done, line_out, line_oe);
	modport sync (input raw_in, output line_lvl, line_chg);
endinterface

// ### rtl/pin_sync.sv
// Three-stage synchroniser and agreement filter for the receive pin
module pin_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Pin side
	coder_if.sync    pin
);
	import coder_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
		logic chg;
	} sync_reg_t;

	sync_reg_t r;
	sync_reg_t n;

	always_comb begin
		n = r;
		n.s1 = pin.raw_in;
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.chg = 1'b0;
		// Level counts only once stages two and three agree
		if (r.s2 == r.s3 && r.s3 != r.lvl) begin
			n.lvl = r.s3;
			n.chg = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '{s1: LINE_IDLE, s2: LINE_IDLE, s3: LINE_IDLE, lvl: LINE_IDLE, chg: 1'b0};
		end else begin
			r <= n;
		end
	end

	assign pin.line_lvl = r.lvl;
	assign pin.line_chg = r.chg;
endmodule

// ### rtl/tx_coder.sv
// Transmit bit stuffer and NRZI encoder
module tx_coder (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Coder link
	coder_if.tx      cd
);
	import coder_pkg::*;

	typedef enum logic [1:0] {TX_IDLE = 2'h1, TX_DATA = 2'h2} tx_state_t;
	typedef struct packed {
		tx_state_t  st;
		logic [2:0] ones;
		logic       level;
		logic       oe;
		logic       ready;
		logic       done;
	} tx_reg_t;

	tx_reg_t r;
	tx_reg_t n;
	logic    take;

	always_comb begin
		take = cd.bit_stb && r.ready && cd.tx_valid;
		n = r;
		n.done = 1'b0;
		if (!cd.enable) begin
			n.st = TX_IDLE;
			n.ones = 3'h0;
			n.level = LINE_IDLE;
			n.oe = 1'b0;
		end else if (cd.bit_stb) begin
			unique case (r.st)
				TX_IDLE: begin
					// Run count starts at first sync bit
					if (take) begin
						n.st = TX_DATA;
						n.oe = 1'b1;
						n.level = cd.tx_bit ? r.level : ~r.level;
						n.ones = cd.tx_bit ? 3'h1 : 3'h0;
					end
				end
				TX_DATA: begin
					if (r.ones == STUFF_RUN) begin
						n.level = ~r.level;
						n.ones = 3'h0;
					end else if (take) begin
						n.level = cd.tx_bit ? r.level : ~r.level;
						n.ones = cd.tx_bit ? r.ones + 3'h1 : 3'h0;
					// End only after any pending stuff
					end else begin
						n.st = TX_IDLE;
						n.ones = 3'h0;
						n.level = LINE_IDLE;
						n.oe = 1'b0;
						n.done = 1'b1;
					end
				end
			endcase
		end
		n.ready = cd.enable && n.ones != STUFF_RUN;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '{st: TX_IDLE, ones: 3'h0, level: LINE_IDLE, oe: 1'b0, ready: 1'b0, done: 1'b0};
		end else begin
			r <= n;
		end
	end

	assign cd.tx_ready = r.ready;
	assign cd.tx_done  = r.done;
	assign cd.line_out = r.level;
	assign cd.line_oe  = r.oe;

	a_stuff_zero_sent: assert property (@(posedge clk) disable iff (!arst_n)
		cd.bit_stb && cd.enable && r.st == TX_DATA && r.ones == STUFF_RUN
		|=> r.oe && r.level != $past(r.level) && r.ones == 3'h0)
		else $error("stuffed zero not sent after six ones");
	a_nrzi_one_hold: assert property (@(posedge clk) disable iff (!arst_n)
		take && cd.enable && cd.tx_bit |=> r.oe && r.level == $past(r.level))
		else $error("one bit changed the line level");
	a_nrzi_zero_flip: assert property (@(posedge clk) disable iff (!arst_n)
		take && cd.enable && !cd.tx_bit |=> r.oe && r.level != $past(r.level))
		else $error("zero bit did not flip the line level");
	a_idle_is_j: assert property (@(posedge clk) disable iff (!arst_n)
		!r.oe |-> r.level == LINE_IDLE)
		else $error("undriven line reference is not J");
	a_ready_stall: assert property (@(posedge clk) disable iff (!arst_n)
		cd.bit_stb && cd.enable && r.ones == STUFF_RUN |-> !r.ready ##1 r.ready)
		else $error("serializer not stalled for stuffed bit");
endmodule

// ### rtl/usb_line_coder.sv
// Low-speed USB line coder: registers, bit timing and receive decoder
module usb_line_coder #(
	parameter logic [4:0] RX_CYC = coder_pkg::RX_BIT_CYC
) (
	// Clock and reset
	input  wire logic                        CLK,
	input  wire logic                        ARST_N,
	// AHB-Lite slave
	input  wire logic                        HSEL,
	input  wire logic [coder_pkg::AHB_DW-1:0] HADDR,
	input  wire logic [1:0]                  HTRANS,
	input  wire logic                        HWRITE,
	input  wire logic [2:0]                  HSIZE,
	input  wire logic [coder_pkg::AHB_DW-1:0] HWDATA,
	input  wire logic                        HREADY,
	output logic      [coder_pkg::AHB_DW-1:0] HRDATA,
	output logic                             HREADYOUT,
	output logic                             HRESP,
	// Interrupt
	output logic                             IRQ,
	// Packet logic, transmit
	input  wire logic                        TX_VALID,
	input  wire logic                        TX_BIT,
	output logic                             TX_READY,
	output logic                             TX_DONE,
	// Packet logic, receive
	input  wire logic                        RX_ARM,
	output logic                             RX_BIT,
	output logic                             RX_STROBE,
	output logic                             RX_STUFF_ERR,
	output logic                             RX_BUSY,
	// Transceiver
	input  wire logic                        LINE_IN,
	output logic                             LINE_OUT,
	output logic                             LINE_OE
);
	import coder_pkg::*;

	localparam int SEL_EP   = 0;
	localparam int SEL_CTRL = 1;
	localparam int SEL_MASK = 2;

	if (RX_CYC < 5'h08) begin : g_bad_cyc
		$error("receive bit period too short");
	end
	if (ACC_STEP * 4 > ACC_MOD) begin : g_bad_rate
		$error("clock too slow for the bit rate");
	end
	if (RX_MID_CYC >= RX_CYC) begin : g_bad_mid
		$error("receive sample point beyond the bit period");
	end

	typedef struct packed {
		logic [8:0]       acc;
		logic             bit_stb;
		logic [2:0]       wsel;
		logic [31:0]      rdata;
		logic             hready;
		logic             hresp;
		logic [7:0]       ep_ctrl;
		logic [7:0]       ctrl;
		logic [EVT_W-1:0] stat;
		logic [EVT_W-1:0] mask;
		logic             irq;
		logic             busy;
		logic [4:0]       phase;
		logic             prev;
		logic [2:0]       ones;
		logic             rx_bit;
		logic             rx_stb;
		logic             rx_err;
		logic             rx_start;
	} top_reg_t;

	localparam top_reg_t TOP_RST = '{
		acc:      9'h000,
		bit_stb:  1'b0,
		wsel:     3'h0,
		rdata:    32'h0000_0000,
		hready:   1'b1,
		hresp:    1'b0,
		ep_ctrl:  EP_CTRL2_RST,
		ctrl:     CTRL_RST,
		stat:     STAT_RST,
		mask:     MASK_RST,
		irq:      1'b0,
		busy:     1'b0,
		phase:    5'h00,
		prev:     LINE_IDLE,
		ones:     3'h0,
		rx_bit:   1'b0,
		rx_stb:   1'b0,
		rx_err:   1'b0,
		rx_start: 1'b0
	};

	top_reg_t         r;
	top_reg_t         n;
	logic             addr_ph;
	logic             samp;
	logic             bitv;
	logic [EVT_W-1:0] evt;
	logic [EVT_W-1:0] clr;

	coder_if cd ();

	tx_coder u_tx (
		.clk    (CLK),
		.arst_n (ARST_N),
		.cd     (cd)
	);

	pin_sync u_sync (
		.clk    (CLK),
		.arst_n (ARST_N),
		.pin    (cd)
	);

	assign cd.bit_stb  = r.bit_stb;
	assign cd.enable   = r.ctrl[CTRL_EN_POS];
	assign cd.tx_valid = TX_VALID;
	assign cd.tx_bit   = TX_BIT;
	assign cd.raw_in   = LINE_IN;

	always_comb begin
		n = r;
		clr = '0;
		evt = '0;
		samp = 1'b0;
		bitv = (cd.line_lvl == r.prev);

		// Fractional divider, 1.5 MHz average strobe
		if (r.acc >= ACC_MOD - ACC_STEP) begin
			n.acc = r.acc + ACC_STEP - ACC_MOD;
			n.bit_stb = 1'b1;
		end else begin
			n.acc = r.acc + ACC_STEP;
			n.bit_stb = 1'b0;
		end

		// Address phase: word transfers only
		addr_ph = HSEL && HTRANS[1] && HREADY && HSIZE == HSIZE_WORD;
		n.wsel = 3'h0;
		n.hready = 1'b1;
		n.hresp = 1'b0;
		if (addr_ph && HWRITE) begin
			n.wsel[SEL_EP] = (HADDR == EP_CTRL2_ADDR);
			n.wsel[SEL_CTRL] = (HADDR == CTRL_ADDR);
			n.wsel[SEL_MASK] = (HADDR == MASK_ADDR);
		end else if (addr_ph) begin
			case (HADDR)
				EP_CTRL2_ADDR: begin
					n.rdata = 32'(r.ep_ctrl);
				end
				CTRL_ADDR: begin
					n.rdata = 32'(r.ctrl);
				end
				STAT_ADDR: begin
					n.rdata = 32'(r.stat);
					clr = r.stat;
				end
				MASK_ADDR: begin
					n.rdata = 32'(r.mask);
				end
				LINE_ADDR: begin
					n.rdata = 32'({r.busy, cd.line_oe, cd.tx_ready, r.ctrl[CTRL_EN_POS]});
				end
				default: begin
					n.rdata = 32'h0000_0000;
				end
			endcase
		end

		// Data phase: write data lands
		if (r.wsel[SEL_EP]) begin
			n.ep_ctrl = HWDATA[7:0] & EP_CTRL2_WMASK;
		end
		if (r.wsel[SEL_CTRL]) begin
			n.ctrl = HWDATA[7:0] & CTRL_WMASK;
		end
		if (r.wsel[SEL_MASK]) begin
			n.mask = HWDATA[EVT_W-1:0];
		end

		// Receive decoder
		n.rx_stb = 1'b0;
		n.rx_err = 1'b0;
		n.rx_start = 1'b0;
		if (!r.ctrl[CTRL_EN_POS] || !RX_ARM) begin
			n.busy = 1'b0;
		end else if (!r.busy) begin
			// Decoding starts at the first K of sync
			if (cd.line_chg && cd.line_lvl != LINE_IDLE) begin
				n.busy = 1'b1;
				n.phase = 5'h00;
				n.prev = LINE_IDLE;
				n.ones = 3'h0;
				n.rx_start = 1'b1;
			end
		end else begin
			// Each line edge re-centres the sample point
			if (cd.line_chg || r.phase == RX_CYC - 5'h01) begin
				n.phase = 5'h00;
			end else begin
				n.phase = r.phase + 5'h01;
			end
			samp = (r.phase == RX_MID_CYC);
			if (samp) begin
				n.prev = cd.line_lvl;
				if (r.ones == STUFF_RUN) begin
					n.ones = 3'h0;
					// Seventh one is a stuffing violation
					if (bitv) begin
						n.rx_err = 1'b1;
						n.busy = 1'b0;
					end
				// Deliver decoded bit, stuffed zero dropped above
				end else begin
					n.rx_stb = 1'b1;
					n.rx_bit = bitv;
					// Run continues from sync into identifier
					n.ones = bitv ? r.ones + 3'h1 : 3'h0;
				end
			end
		end

		// Sticky events, a set beats a same-cycle read clear
		evt[EVT_RX_ERR] = n.rx_err;
		evt[EVT_TX_DONE] = cd.tx_done;
		evt[EVT_RX_START] = n.rx_start;
		n.stat = (r.stat & ~clr) | evt;
		n.irq = |(n.stat & n.mask);
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			r <= TOP_RST;
		end else begin
			r <= n;
		end
	end

	assign HRDATA       = r.rdata;
	assign HREADYOUT    = r.hready;
	assign HRESP        = r.hresp;
	assign IRQ          = r.irq;
	assign TX_READY     = cd.tx_ready;
	assign TX_DONE      = cd.tx_done;
	assign RX_BIT       = r.rx_bit;
	assign RX_STROBE    = r.rx_stb;
	assign RX_STUFF_ERR = r.rx_err;
	assign RX_BUSY      = r.busy;
	assign LINE_OUT     = cd.line_out;
	assign LINE_OE      = cd.line_oe;

	// Cycles between bit strobes, for checking only
	logic [4:0] gap_q;
	logic       gap_seen;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			gap_q <= 5'h00;
			gap_seen <= 1'b0;
		end else if (r.bit_stb) begin
			gap_q <= 5'h00;
			gap_seen <= 1'b1;
		end else begin
			gap_q <= gap_q + 5'h01;
		end
	end

	a_bit_strobe_gap: assert property (@(posedge CLK) disable iff (!ARST_N)
		r.bit_stb && gap_seen |-> gap_q == 5'h19 || gap_q == 5'h1A)
		else $error("bit strobe spacing off the 1.5 Mb/s rate");
	a_strobe_single: assert property (@(posedge CLK) disable iff (!ARST_N)
		r.bit_stb |=> !r.bit_stb [*8])
		else $error("bit strobe repeats too soon");
	a_stuffed_dropped: assert property (@(posedge CLK) disable iff (!ARST_N)
		r.busy && samp && r.ones == STUFF_RUN && !bitv
		|=> !r.rx_stb && r.ones == 3'h0 && !r.rx_err)
		else $error("stuffed zero passed onward");
	a_stuff_violation: assert property (@(posedge CLK) disable iff (!ARST_N)
		r.busy && samp && r.ones == STUFF_RUN && bitv |=> r.rx_err && !r.busy && r.stat[EVT_RX_ERR])
		else $error("stuffing violation not reported");
	a_nrzi_decode: assert property (@(posedge CLK) disable iff (!ARST_N)
		r.rx_stb |-> r.rx_bit == ($past(cd.line_lvl) == $past(r.prev)))
		else $error("receive NRZI decode wrong");
	a_run_continues: assert property (@(posedge CLK) disable iff (!ARST_N)
		r.rx_stb && r.rx_bit |-> r.ones == $past(r.ones) + 3'h1)
		else $error("consecutive ones count broken");
	a_first_k_zero: assert property (@(posedge CLK) disable iff (!ARST_N)
		r.rx_start |-> r.busy && r.prev == LINE_IDLE && r.ones == 3'h0)
		else $error("decoder not started from J reference");
	a_irq_level: assert property (@(posedge CLK) disable iff (!ARST_N)
		r.irq == |(r.stat & r.mask))
		else $error("interrupt out of step with status and mask");

	// Register bus and status checks
	a_stat_read_clear: assert property (@(posedge CLK) disable iff (!ARST_N)
		addr_ph && !HWRITE && HADDR == STAT_ADDR |=> r.stat == $past(evt))
		else $error("status read did not clear the read bits");
	a_stat_sticky: assert property (@(posedge CLK) disable iff (!ARST_N)
		!(addr_ph && !HWRITE && HADDR == STAT_ADDR) |=> (r.stat & $past(r.stat)) == $past(r.stat))
		else $error("status bit lost without a read");
	a_event_set_wins: assert property (@(posedge CLK) disable iff (!ARST_N)
		evt != '0 |=> (r.stat & $past(evt)) == $past(evt))
		else $error("status event lost");
	a_ep_write_lands: assert property (@(posedge CLK) disable iff (!ARST_N)
		r.wsel[SEL_EP] |=> r.ep_ctrl == ($past(HWDATA[7:0]) & EP_CTRL2_WMASK))
		else $error("endpoint control write did not land");
	a_mask_write_lands: assert property (@(posedge CLK) disable iff (!ARST_N)
		r.wsel[SEL_MASK] |=> r.mask == $past(HWDATA[EVT_W-1:0]))
		else $error("mask write did not land");
	a_read_data_held: assert property (@(posedge CLK) disable iff (!ARST_N)
		!(addr_ph && !HWRITE) |=> $stable(r.rdata))
		else $error("read data changed without a read");

	// Receive decoder checks
	a_rx_abort: assert property (@(posedge CLK) disable iff (!ARST_N)
		!RX_ARM || !r.ctrl[CTRL_EN_POS] |=> !r.busy)
		else $error("decoder busy while disarmed");
	a_rx_start_k: assert property (@(posedge CLK) disable iff (!ARST_N)
		!r.busy && r.ctrl[CTRL_EN_POS] && RX_ARM && cd.line_chg && cd.line_lvl != LINE_IDLE |=> r.busy && r.rx_start)
		else $error("decoder did not start on K");
	a_phase_range: assert property (@(posedge CLK) disable iff (!ARST_N)
		r.busy |-> r.phase < RX_CYC)
		else $error("bit phase beyond the bit period");
	a_rx_pulse_single: assert property (@(posedge CLK) disable iff (!ARST_N)
		r.rx_stb || r.rx_err |=> !r.rx_stb && !r.rx_err)
		else $error("receive pulse longer than one cycle");
	a_err_ends_packet: assert property (@(posedge CLK) disable iff (!ARST_N)
		r.rx_err |-> !r.busy && !r.rx_stb && r.stat[EVT_RX_ERR])
		else $error("stuffing violation did not end the packet");
endmodule

// ### test/usb_host_model.sv
// Behavioural host port: NRZI line driver and decoder
module usb_host_model (
	// Device line
	input  wire logic line_out,
	input  wire logic line_oe,
	// Host drive
	output logic      line_in
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam real BIT_NS = 666.667;
	logic rx_q[$];
	logic lvl;
	logic prev;
	initial begin
		line_in = 1'b1;
		lvl = 1'b1;
	end
	// NRZI transmit at the low-speed bit rate
	task automatic send(input logic [31:0] b, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			if (b[i] == 1'b0)
				lvl = ~lvl;
			line_in = lvl;
			#(BIT_NS);
		end
		lvl = 1'b1;
		line_in = 1'b1;
	endtask
	always begin
		@(posedge line_oe);
		prev = 1'b1;
		#(BIT_NS / 2);
		while (line_oe === 1'b1) begin
			rx_q.push_back(line_out === prev);
			prev = line_out;
			#(BIT_NS);
		end
	end
endmodule

// ### test/usb_ls_nrzi_bit_stuffing_tb.sv
// Self-checking bench of the low-speed line coder
module usb_ls_nrzi_bit_stuffing_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import coder_pkg::*;
	localparam logic [21:0] TX_RAW  = 22'h00_7E7E;
	localparam logic [19:0] TX_DATA = 20'h0_1FBF;
	localparam logic [14:0] VIOL    = 15'h00FF;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0]  htrans = '0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = '0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, irq, tx_ready, tx_done, line_in, line_out, line_oe;
	logic        rx_bit, rx_strobe, rx_stuff_err, rx_busy;
	logic        tx_valid = 1'b0;
	logic        tx_bit = 1'b0;
	logic        rx_arm = 1'b0;
	int          mismatches, n_tests, cyc, n_err;
	logic        rxq[$];

	always #12.5 clk = ~clk;

	usb_line_coder i_usb_line_coder (
		.CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
		.HRESP(hresp), .IRQ(irq), .TX_VALID(tx_valid), .TX_BIT(tx_bit), .TX_READY(tx_ready),
		.TX_DONE(tx_done), .RX_ARM(rx_arm), .RX_BIT(rx_bit), .RX_STROBE(rx_strobe),
		.RX_STUFF_ERR(rx_stuff_err), .RX_BUSY(rx_busy), .LINE_IN(line_in), .LINE_OUT(line_out),
		.LINE_OE(line_oe));
	usb_host_model i_usb_host_model (.line_out(line_out), .line_oe(line_oe), .line_in(line_in));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic final_report();
		if (mismatches == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Hang guard and receive capture
	always @(posedge clk) begin
		cyc++;
		if (rx_strobe === 1'b1)
			rxq.push_back(rx_bit);
		if (rx_stuff_err === 1'b1)
			n_err++;
		if (cyc == 30000) begin
			mismatches++;
			final_report();
		end
	end

	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		hsize <= HSIZE_WORD;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [31:0] a, input string nm, input logic [31:0] exp);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0000_0000, r);
		chk(nm, r, exp);
		chk("hresp", 32'(hresp), 32'h0000_0000);
	endtask

	task automatic t_reset();
		chk("line_out", line_out, 32'h0000_0001);
		chk("line_oe", line_oe, 32'h0000_0000);
		rd(EP_CTRL2_ADDR, "ep_ctrl2", 32'h0000_0000);
		wr(EP_CTRL2_ADDR, 32'hFFFF_FFFF);
		rd(EP_CTRL2_ADDR, "ep_ctrl2", 32'h0000_002F);
		rd(CTRL_ADDR, "ctrl", 32'h0000_0001);
		rd(LINE_ADDR, "line", 32'h0000_0003);
		rd(STAT_ADDR, "stat", 32'h0000_0000);
		rd(MASK_ADDR, "mask", 32'h0000_0000);
		rd(32'h0000_0200, "unmapped", 32'h0000_0000);
	endtask

	task automatic t_tx();
		int n;
		int k;
		int i;
		int stall;
		n = 0;
		stall = 0;
		k = 1;
		i = 1;
		tx_bit <= TX_DATA[19];
		tx_valid <= 1'b1;
		while (line_oe !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		n = 1;
		// Present bits mid-slot, hold while a stuffed zero goes out
		while (i <= 20 && n < 2000) begin
			@(posedge clk);
			n++;
			if (n * 15 >= (k - 1) * 400 + 195) begin
				k++;
				if (tx_ready === 1'b1) begin
					if (i < 20)
						tx_bit <= TX_DATA[19 - i];
					else
						tx_valid <= 1'b0;
					i++;
				end else begin
					stall++;
				end
			end
		end
		n = 0;
		while (tx_done !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk("tx_done", tx_done, 32'h0000_0001);
		chk("tx_stall", stall, 32'd2);
		repeat (30) @(posedge clk);
		chk("tx_len", i_usb_host_model.rx_q.size(), 32'd22);
		for (int j = 0; j < 22; j++)
			chk("tx_line_bit", i_usb_host_model.rx_q[j], TX_RAW[21 - j]);
		chk("irq", irq, 32'h0000_0000);
		wr(MASK_ADDR, 32'h0000_0002);
		repeat (2) @(posedge clk);
		chk("irq", irq, 32'h0000_0001);
		rd(STAT_ADDR, "stat", 32'h0000_0002);
		repeat (2) @(posedge clk);
		chk("irq", irq, 32'h0000_0000);
	endtask

	task automatic t_rx();
		rxq.delete();
		rx_arm <= 1'b1;
		@(posedge clk);
		i_usb_host_model.send(32'(TX_RAW), 22);
		chk("rx_busy", rx_busy, 32'h0000_0001);
		@(posedge clk);
		rx_arm <= 1'b0;
		chk("rx_len", rxq.size(), 32'd20);
		for (int j = 0; j < 20; j++)
			chk("rx_bit", rxq[j], TX_DATA[19 - j]);
		rd(STAT_ADDR, "stat", 32'h0000_0004);
	endtask

	task automatic t_viol();
		n_err = 0;
		rx_arm <= 1'b1;
		@(posedge clk);
		i_usb_host_model.send(32'(VIOL), 15);
		chk("rx_busy", rx_busy, 32'h0000_0000);
		@(posedge clk);
		rx_arm <= 1'b0;
		chk("stuff_err", n_err, 32'd1);
		wr(MASK_ADDR, 32'h0000_0001);
		repeat (2) @(posedge clk);
		chk("irq", irq, 32'h0000_0001);
		rd(STAT_ADDR, "stat", 32'h0000_0005);
		repeat (2) @(posedge clk);
		chk("irq", irq, 32'h0000_0000);
	endtask

	initial begin
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_tx();
		t_rx();
		t_viol();
		final_report();
	end
endmodule
